// >>> logic/hspir_pkg.sv
// register map, field positions and reset values of the sensor register block
package hspir_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 16;
  localparam int NFLAG = 5;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_TEMP_LO = 8'h00;
  localparam logic [7:0] OFF_TEMP_HI = 8'h01;
  localparam logic [7:0] OFF_HUM_LO = 8'h02;
  localparam logic [7:0] OFF_HUM_HI = 8'h03;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_PEAK_T = 8'h05;
  localparam logic [7:0] OFF_PEAK_H = 8'h06;
  localparam logic [7:0] OFF_IRQ_EN = 8'h07;
  localparam logic [7:0] OFF_TRIM = 8'h08;
  localparam logic [7:0] OFF_DEV_CFG = 8'h0E;

  // ****************************************************************
  // field layout
  // ****************************************************************
  // flag and enable bytes share one layout: bits 7..3, low three reserved
  localparam int FLAG_LSB = 3;
  localparam int BIT_DONE = 4;
  localparam int BIT_T_ABOVE = 3;
  localparam int BIT_T_BELOW = 2;
  localparam int BIT_H_ABOVE = 1;
  localparam int BIT_H_BELOW = 0;
  localparam logic [7:0] FLAG_BYTE_MASK = 8'hF8;
  localparam int CFG_SOFT_RST_BIT = 7;
  localparam int CFG_RATE_LSB = 4;
  localparam int CFG_ALERT_ON_BIT = 2;
  localparam logic [7:0] CFG_STORE_MASK = 8'h7F;
  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;

  // ****************************************************************
  // reset values and arithmetic
  // ****************************************************************
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  // one trim step of 0.16 degC equals 64 counts of the 16-bit temperature code
  localparam int TRIM_SHIFT = 6;
endpackage

// >>> logic/hspir_top.sv
// result, status flag, peak hold, alert enable and temperature trim registers
`timescale 1ns/1ps
module hspir_top (
  input wire logic sys_clk_in, // 50 MHz device clock
  input wire logic rst_n_in, // power-on reset, active low, asynchronous
  input wire logic ptr_wr_in, // pointer byte strobe from the serial engine
  input wire logic [7:0] ptr_data_in, // new register pointer
  input wire logic data_wr_in, // data byte write strobe
  input wire logic [7:0] wdata_in, // data byte written
  input wire logic data_rd_in, // data byte read strobe
  output logic [7:0] rdata_out, // read data, valid the cycle after data_rd_in
  input wire logic temp_done_in, // temperature conversion complete pulse
  input wire logic [15:0] temp_raw_in, // raw temperature code with temp_done_in
  input wire logic hum_done_in, // humidity conversion complete pulse
  input wire logic [15:0] hum_raw_in, // humidity code with hum_done_in
  input wire logic [3:0] thr_evt_in, // threshold exceeded pulses: t_above,t_below,h_above,h_below
  output logic alert_out // alert pin level, active high
);
  logic rst_meta_q;
  logic rst_n_q;
  logic soft_q;
  logic [7:0] ptr_q;
  logic [15:0] temp_q;
  logic [15:0] hum_q;
  logic [4:0] flags_q;
  logic [4:0] irq_en_q;
  logic [7:0] trim_q;
  logic [7:0] cfg_q;
  logic [7:0] peak_t_q;
  logic [7:0] peak_h_q;
  logic [15:0] temp_adj;
  logic one_shot;
  logic wr_hit_cfg;
  logic rd_result;
  logic rd_flags;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [7:0] flag_byte;

  // ****************************************************************
  // functions
  // ****************************************************************
  // signed trim scaled onto the 16-bit code, clamped instead of wrapping
  function automatic logic [15:0] apply_trim(input logic [15:0] raw, input logic [7:0] t);
    logic signed [17:0] step;
    logic signed [17:0] sum;
    step = 18'($signed(t)) <<< hspir_pkg::TRIM_SHIFT;
    sum = $signed({2'h0, raw}) + step;
    if (sum[17]) begin
      apply_trim = hspir_pkg::WORD_RESET;
    end else if (sum[16]) begin
      apply_trim = hspir_pkg::WORD_MAX;
    end else begin
      apply_trim = sum[15:0];
    end
  endfunction

  function automatic logic [7:0] to_byte(input logic [4:0] v);
    to_byte = {v, 3'h0};
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  assign temp_adj = apply_trim(temp_raw_in, trim_q);
  assign one_shot = (cfg_q[hspir_pkg::CFG_RATE_LSB +: 3] == hspir_pkg::RATE_ONE_SHOT);
  assign wr_hit_cfg = data_wr_in && (ptr_q == hspir_pkg::OFF_DEV_CFG);
  assign rd_result = data_rd_in && (ptr_q <= hspir_pkg::OFF_FLAGS);
  assign rd_flags = data_rd_in && (ptr_q == hspir_pkg::OFF_FLAGS);
  assign flag_set = {temp_done_in | hum_done_in, thr_evt_in};
  assign flag_clr = {rd_result, {4{rd_flags}}};
  assign flag_byte = to_byte(flags_q);

  // ****************************************************************
  // soft reset: the bit reads one for a single cycle, then every register but the pointer, rdata_out and alert_out clears
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_hit_cfg && wdata_in[hspir_pkg::CFG_SOFT_RST_BIT] && !soft_q;
    end
  end

  // ****************************************************************
  // register pointer
  // ****************************************************************
  // pointer is left alone by soft reset so a transfer in flight stays aligned
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_q <= hspir_pkg::BYTE_RESET;
    end else if (ptr_wr_in) begin
      ptr_q <= ptr_data_in;
    end else if (data_wr_in || data_rd_in) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // ****************************************************************
  // results
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      temp_q <= hspir_pkg::WORD_RESET;
      hum_q <= hspir_pkg::WORD_RESET;
    end else if (soft_q) begin
      temp_q <= hspir_pkg::WORD_RESET;
      hum_q <= hspir_pkg::WORD_RESET;
    end else begin
      if (temp_done_in) begin
        temp_q <= temp_adj;
      end
      if (hum_done_in) begin
        hum_q <= hum_raw_in;
      end
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  // a new event in the cycle of the clearing read wins, so none is lost
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= 5'h00;
    end else if (soft_q) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  // ****************************************************************
  // peak hold
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      peak_t_q <= hspir_pkg::BYTE_RESET;
      peak_h_q <= hspir_pkg::BYTE_RESET;
    end else if (soft_q) begin
      peak_t_q <= hspir_pkg::BYTE_RESET;
      peak_h_q <= hspir_pkg::BYTE_RESET;
    end else if (one_shot) begin
      if (temp_done_in && (temp_adj[15:8] > peak_t_q)) begin
        peak_t_q <= temp_adj[15:8];
      end
      if (hum_done_in && (hum_raw_in[15:8] > peak_h_q)) begin
        peak_h_q <= hum_raw_in[15:8];
      end
    end
  end

  // ****************************************************************
  // writable registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_en_q <= 5'h00;
      trim_q <= hspir_pkg::BYTE_RESET;
      cfg_q <= hspir_pkg::BYTE_RESET;
    end else if (soft_q) begin
      irq_en_q <= 5'h00;
      trim_q <= hspir_pkg::BYTE_RESET;
      cfg_q <= hspir_pkg::BYTE_RESET;
    end else if (data_wr_in) begin
      unique case (ptr_q)
        hspir_pkg::OFF_IRQ_EN: irq_en_q <= wdata_in[7:hspir_pkg::FLAG_LSB];
        hspir_pkg::OFF_TRIM: trim_q <= wdata_in;
        hspir_pkg::OFF_DEV_CFG: cfg_q <= wdata_in & hspir_pkg::CFG_STORE_MASK;
        default: begin
          // read-only and unmapped offsets ignore writes
        end
      endcase
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_out <= hspir_pkg::BYTE_RESET;
    end else if (data_rd_in) begin
      unique case (ptr_q)
        hspir_pkg::OFF_TEMP_LO: rdata_out <= temp_q[7:0];
        hspir_pkg::OFF_TEMP_HI: rdata_out <= temp_q[15:8];
        hspir_pkg::OFF_HUM_LO: rdata_out <= hum_q[7:0];
        hspir_pkg::OFF_HUM_HI: rdata_out <= hum_q[15:8];
        hspir_pkg::OFF_FLAGS: rdata_out <= flag_byte;
        hspir_pkg::OFF_PEAK_T: rdata_out <= peak_t_q;
        hspir_pkg::OFF_PEAK_H: rdata_out <= peak_h_q;
        hspir_pkg::OFF_IRQ_EN: rdata_out <= to_byte(irq_en_q);
        hspir_pkg::OFF_TRIM: rdata_out <= trim_q;
        hspir_pkg::OFF_DEV_CFG: rdata_out <= {soft_q, cfg_q[6:0]};
        default: rdata_out <= hspir_pkg::BYTE_RESET;
      endcase
    end
  end

  // ****************************************************************
  // alert
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alert_out <= 1'b0;
    end else begin
      alert_out <= cfg_q[hspir_pkg::CFG_ALERT_ON_BIT] && |(flags_q & irq_en_q);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_q);

  AST_HUM_UPPER: assert property (
    data_rd_in && ptr_q == hspir_pkg::OFF_HUM_HI
    |=> rdata_out == $past(hum_q[15:8]))
    else $error("humidity upper byte does not match stored result");
  AST_RESERVED_ZERO: assert property (
    data_rd_in && (ptr_q == hspir_pkg::OFF_FLAGS || ptr_q == hspir_pkg::OFF_IRQ_EN)
    |=> rdata_out[2:0] == 3'h0)
    else $error("reserved bits read nonzero");
  AST_DONE_SET: assert property (
    (temp_done_in || hum_done_in) && !soft_q |=> flags_q[hspir_pkg::BIT_DONE])
    else $error("done flag not set by conversion");
  AST_DONE_CLR: assert property (
    rd_result && !temp_done_in && !hum_done_in |=> !flags_q[hspir_pkg::BIT_DONE])
    else $error("done flag survives result read");
  AST_THR_SET: assert property (
    thr_evt_in[hspir_pkg::BIT_T_ABOVE] && !soft_q |=> flags_q[hspir_pkg::BIT_T_ABOVE])
    else $error("threshold flag not set");
  AST_THR_CLR: assert property (
    rd_flags && thr_evt_in == 4'h0 |=> flags_q[3:0] == 4'h0)
    else $error("threshold flags survive flag read");
  AST_THR_KEEP: assert property (
    flags_q[hspir_pkg::BIT_H_BELOW] && !rd_flags && !soft_q |=> flags_q[hspir_pkg::BIT_H_BELOW])
    else $error("threshold flag lost without read");
  AST_SOFT_CLEARS: assert property (
    wr_hit_cfg && wdata_in[hspir_pkg::CFG_SOFT_RST_BIT] && !soft_q
    |=> soft_q ##1 (!soft_q && flags_q == 5'h00 && irq_en_q == 5'h00 && peak_t_q == 8'h00))
    else $error("soft reset did not clear and self-clear");
  AST_PEAK_MONO: assert property (
    !soft_q |=> peak_t_q >= $past(peak_t_q) && peak_h_q >= $past(peak_h_q))
    else $error("peak value decreased without reset");
  AST_PEAK_CONT: assert property (
    !one_shot && !soft_q |=> $stable(peak_t_q) && $stable(peak_h_q))
    else $error("peak changed in continuous mode");
  AST_PEAK_TRACK: assert property (
    one_shot && hum_done_in && !soft_q |=> peak_h_q >= $past(hum_raw_in[15:8]))
    else $error("peak humidity below converted value");
  AST_ENABLE_RW: assert property (
    data_wr_in && ptr_q == hspir_pkg::OFF_IRQ_EN && !soft_q
    |=> irq_en_q == $past(wdata_in[7:hspir_pkg::FLAG_LSB]))
    else $error("enable write did not land");
  AST_ALERT_SOURCE: assert property (
    alert_out |-> $past(|(flags_q & irq_en_q)))
    else $error("alert with no enabled flag");
  AST_ALERT_MASTER: assert property (
    !cfg_q[hspir_pkg::CFG_ALERT_ON_BIT] |=> !alert_out)
    else $error("alert without master enable");
  AST_ALERT_ON: assert property (
    cfg_q[hspir_pkg::CFG_ALERT_ON_BIT] && flags_q[hspir_pkg::BIT_DONE]
    && irq_en_q[hspir_pkg::BIT_DONE] |=> alert_out)
    else $error("enabled flag did not raise alert");
  AST_TRIM_NEG: assert property (
    trim_q == 8'hFF && temp_done_in && !soft_q && temp_raw_in >= 16'h0040
    |=> temp_q == $past(temp_raw_in) - 16'h0040)
    else $error("minus one trim step misapplied");
  AST_PTR_INC: assert property (
    (data_rd_in || data_wr_in) && !ptr_wr_in |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance");

  COV_DONE_READ: cover property (temp_done_in ##[1:20] rd_flags);
  COV_PEAK_UP: cover property (one_shot && temp_done_in ##1 $changed(peak_t_q));
  COV_SOFT: cover property (soft_q);
  COV_ALERT: cover property ($rose(alert_out));
endmodule

// >>> sim/hspir_host_model.sv
// host side model: pointer, write and read cycles on the register port
`timescale 1ns/1ps
module hspir_host_model (
  input wire logic clk_in, // device clock
  input wire logic [7:0] rdata_in, // read data from the block
  output logic ptr_wr_out, // pointer strobe
  output logic [7:0] ptr_data_out, // pointer value
  output logic data_wr_out, // write strobe
  output logic [7:0] wdata_out, // write data
  output logic data_rd_out // read strobe
);
  initial begin
    ptr_wr_out = 1'b0;
    ptr_data_out = 8'h00;
    data_wr_out = 1'b0;
    wdata_out = 8'h00;
    data_rd_out = 1'b0;
  end
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  task automatic set_ptr(input logic [7:0] a);
    @(posedge clk_in);
    ptr_wr_out <= 1'b1;
    ptr_data_out <= a;
    @(posedge clk_in);
    ptr_wr_out <= 1'b0;
    ptr_data_out <= ~a; // stale bus must not pass for the old pointer
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    set_ptr(a);
    @(posedge clk_in);
    data_wr_out <= 1'b1;
    wdata_out <= d;
    @(posedge clk_in);
    data_wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // next byte of a multibyte read relies on the block stepping its pointer
  task automatic rd_next(output logic [7:0] d);
    @(posedge clk_in);
    data_rd_out <= 1'b1;
    @(posedge clk_in);
    data_rd_out <= 1'b0;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    set_ptr(a);
    rd_next(d);
  endtask
  // ****************************************************************
  // host scaling, hundredths of a unit
  // ****************************************************************
  function automatic int rh_centi(input logic [15:0] c);
    return (int'(c) * 10000) >>> 16;
  endfunction
  function automatic int peak_t_centi(input logic [7:0] c);
    return (int'(c) * 16500) / 256 - 4000;
  endfunction
  function automatic int peak_h_centi(input logic [7:0] c);
    return (int'(c) * 10000) / 256;
  endfunction
endmodule

// >>> sim/hspir_top_bench.sv
// self-checking bench for the sensor register block
`timescale 1ns/1ps
module hspir_top_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ptr_wr;
  logic [7:0] ptr_data;
  logic data_wr;
  logic [7:0] wdata;
  logic data_rd;
  logic [7:0] rdata;
  logic temp_done = 1'b0;
  logic [15:0] temp_raw = 16'h0000;
  logic hum_done = 1'b0;
  logic [15:0] hum_raw = 16'h0000;
  logic [3:0] thr_evt = 4'h0;
  logic alert;
  logic [7:0] rd_v;
  int mismatches = 0;
  int cmp_count = 0;

  always #10 sys_clk = ~sys_clk;

  hspir_top hspir_top_inst (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ptr_wr_in(ptr_wr),
    .ptr_data_in(ptr_data), .data_wr_in(data_wr), .wdata_in(wdata), .data_rd_in(data_rd),
    .rdata_out(rdata), .temp_done_in(temp_done), .temp_raw_in(temp_raw),
    .hum_done_in(hum_done), .hum_raw_in(hum_raw), .thr_evt_in(thr_evt), .alert_out(alert));
  hspir_host_model hspir_host_model_inst (.clk_in(sys_clk), .rdata_in(rdata),
    .ptr_wr_out(ptr_wr), .ptr_data_out(ptr_data), .data_wr_out(data_wr),
    .wdata_out(wdata), .data_rd_out(data_rd));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    hspir_host_model_inst.rd_reg(a, rd_v);
    chk(what, rd_v, exp);
  endtask
  task automatic nxt_chk(input string what, input logic [7:0] exp);
    hspir_host_model_inst.rd_next(rd_v);
    chk(what, rd_v, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hspir_host_model_inst.wr_reg(a, d);
  endtask
  // alert is registered behind the flag, so let two edges land first
  task automatic alert_chk(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("alert", {7'h00, alert}, {7'h00, exp});
  endtask
  task automatic conv(input logic te, input logic [15:0] t, input logic he,
                      input logic [15:0] h);
    @(posedge sys_clk);
    temp_done <= te;
    temp_raw <= t;
    hum_done <= he;
    hum_raw <= h;
    @(posedge sys_clk);
    temp_done <= 1'b0;
    hum_done <= 1'b0;
    temp_raw <= ~t;
    hum_raw <= ~h;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic thr(input logic [3:0] v);
    @(posedge sys_clk);
    thr_evt <= v;
    @(posedge sys_clk);
    thr_evt <= 4'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (logic [7:0] a = 8'h03; a <= 8'h08; a++) begin
      rd_chk("reset value", a, 8'h00);
    end
    $display("test reset values done");
    wr(hspir_pkg::OFF_IRQ_EN, 8'hFF);
    rd_chk("enables", hspir_pkg::OFF_IRQ_EN, 8'hF8);
    wr(hspir_pkg::OFF_TRIM, 8'h5A);
    rd_chk("trim", hspir_pkg::OFF_TRIM, 8'h5A);
    wr(hspir_pkg::OFF_HUM_HI, 8'hAA);
    rd_chk("humid upper ro", hspir_pkg::OFF_HUM_HI, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(hspir_pkg::OFF_IRQ_EN, 8'h00);
    wr(hspir_pkg::OFF_TRIM, 8'h00);
    $display("test access kinds done");
    conv(1'b1, 16'h8000, 1'b1, 16'h4321);
    rd_chk("flags done", hspir_pkg::OFF_FLAGS, 8'h80);
    rd_chk("humid upper", hspir_pkg::OFF_HUM_HI, 8'h43);
    rd_chk("flags cleared", hspir_pkg::OFF_FLAGS, 8'h00);
    rd_chk("peak temp", hspir_pkg::OFF_PEAK_T, 8'h80);
    nxt_chk("peak humid", 8'h43);
    conv(1'b1, 16'h7000, 1'b1, 16'h9000);
    rd_chk("peak temp kept", hspir_pkg::OFF_PEAK_T, 8'h80);
    rd_chk("peak humid up", hspir_pkg::OFF_PEAK_H, 8'h90);
    $display("test peaks done, rh %0d t %0d h %0d", hspir_host_model_inst.rh_centi(16'h4321),
      hspir_host_model_inst.peak_t_centi(8'h80), hspir_host_model_inst.peak_h_centi(8'h90));
    rd_chk("flags done again", hspir_pkg::OFF_FLAGS, 8'h80);
    for (int i = 0; i < 4; i++) begin
      thr(4'h1 << i);
      rd_chk("threshold flag", hspir_pkg::OFF_FLAGS, 8'h08 << i);
    end
    rd_chk("flags after read", hspir_pkg::OFF_FLAGS, 8'h00);
    $display("test threshold flags done");
    wr(hspir_pkg::OFF_IRQ_EN, 8'h80);
    wr(hspir_pkg::OFF_DEV_CFG, 8'h04);
    conv(1'b1, 16'h2000, 1'b0, 16'h0000);
    alert_chk(1'b1);
    rd_chk("temp lower", hspir_pkg::OFF_TEMP_LO, 8'h00);
    alert_chk(1'b0);
    thr(4'h8);
    alert_chk(1'b0);
    wr(hspir_pkg::OFF_IRQ_EN, 8'hC0);
    alert_chk(1'b1);
    wr(hspir_pkg::OFF_DEV_CFG, 8'h00);
    alert_chk(1'b0);
    rd_chk("flag kept", hspir_pkg::OFF_FLAGS, 8'h40);
    wr(hspir_pkg::OFF_IRQ_EN, 8'h00);
    $display("test alert done");
    wr(hspir_pkg::OFF_TRIM, 8'hFF);
    conv(1'b1, 16'h1010, 1'b0, 16'h0000);
    rd_chk("trim neg lower", hspir_pkg::OFF_TEMP_LO, 8'hD0);
    nxt_chk("trim neg upper", 8'h0F);
    wr(hspir_pkg::OFF_TRIM, 8'h07);
    conv(1'b1, 16'h1010, 1'b0, 16'h0000);
    rd_chk("trim pos lower", hspir_pkg::OFF_TEMP_LO, 8'hD0);
    nxt_chk("trim pos upper", 8'h11);
    $display("test trim done");
    wr(hspir_pkg::OFF_TRIM, 8'h00);
    wr(hspir_pkg::OFF_DEV_CFG, 8'h10);
    conv(1'b1, 16'hF000, 1'b1, 16'hF000);
    rd_chk("peak temp cont", hspir_pkg::OFF_PEAK_T, 8'h80);
    rd_chk("peak humid cont", hspir_pkg::OFF_PEAK_H, 8'h90);
    rd_chk("temp cont", hspir_pkg::OFF_TEMP_HI, 8'hF0);
    $display("test continuous mode done");
    wr(hspir_pkg::OFF_DEV_CFG, 8'h00);
    wr(hspir_pkg::OFF_IRQ_EN, 8'hF8);
    wr(hspir_pkg::OFF_TRIM, 8'h33);
    thr(4'h2);
    wr(hspir_pkg::OFF_DEV_CFG, 8'h80);
    rd_chk("soft reset bit", hspir_pkg::OFF_DEV_CFG, 8'h00);
    rd_chk("peak temp srst", hspir_pkg::OFF_PEAK_T, 8'h00);
    rd_chk("peak humid srst", hspir_pkg::OFF_PEAK_H, 8'h00);
    rd_chk("enables srst", hspir_pkg::OFF_IRQ_EN, 8'h00);
    rd_chk("trim srst", hspir_pkg::OFF_TRIM, 8'h00);
    rd_chk("flags srst", hspir_pkg::OFF_FLAGS, 8'h00);
    $display("test soft reset done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    $display("timeout waiting for the main sequence");
    mismatches++;
    report_and_stop();
  end
endmodule
